// *** flow_tag_pkg.sv ***
`default_nettype none
package flow_tag_pkg;
	// Register byte offsets
	localparam logic [7:0] ctrl_offset   = 8'h00;
	localparam logic [7:0] assoc_offset  = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;
	localparam logic [7:0] drop_offset   = 8'h0c;
	localparam logic [7:0] common_offset = 8'h10;
	localparam logic [7:0] class_offset  = 8'h14;

	// Control register bits
	localparam int ctrl_strip_bit  = 0;
	localparam int ctrl_net_bit    = 1;
	localparam int ctrl_route_bit  = 2;
	localparam int ctrl_common_bit = 3;
	localparam int ctrl_width      = 4;
	localparam logic [3:0] ctrl_reset = 4'h0;

	// Association command word fields
	localparam int idx_lsb   = 0;
	localparam int vid_lsb   = 4;
	localparam int pcp_lsb   = 16;
	localparam int dir_bit   = 19;
	localparam int op_lsb    = 20;
	localparam int valid_bit = 31;
	localparam logic [1:0] op_add         = 2'h1;
	localparam logic [1:0] op_release     = 2'h2;
	localparam logic [1:0] op_flow_delete = 2'h3;
	localparam logic dir_down = 1'b0;
	localparam logic dir_up   = 1'b1;

	// Status bits
	localparam int status_range_bit = 0;
	localparam int status_dup_bit   = 1;

	// Common mapping for dynamic flows: vid [11:0], pcp [14:12]
	localparam int common_pcp_lsb = 12;
	localparam logic [14:0] common_reset = 15'h0000;
	localparam int class_vid_lsb = 4;

	// Tag layout
	localparam logic [15:0] service_tpid  = 16'h88a8;
	localparam logic [15:0] customer_tpid = 16'h8100;
	localparam logic [11:0] vid_min = 12'h801;
	localparam logic [11:0] vid_max = 12'h9d0;
	localparam int modem_index_width = 9;
	localparam logic [2:0] header_beats = 3'h6;
endpackage
`default_nettype wire

// *** tag_inserter.sv ***
`timescale 1ns/10ps
`default_nettype none
module tag_inserter (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic [15:0] in_data,
	input  wire logic        in_valid,
	input  wire logic        in_sop,
	input  wire logic        in_eop,
	output logic             in_ready,
	input  wire logic        hdr_insert,
	input  wire logic        hdr_drop,
	input  wire logic        hdr_strip,
	input  wire logic [15:0] hdr_tpid,
	input  wire logic [15:0] hdr_tci,
	output logic [15:0]      out_data,
	output logic             out_valid,
	output logic             out_sop,
	output logic             out_eop,
	input  wire logic        out_ready
);
	typedef enum {s_addr, s_type, s_strip, s_tpid, s_tci, s_body, s_drop}
		insert_state_type;

	insert_state_type state_reg;
	insert_state_type state_next;
	logic [2:0]  beat_reg;
	logic [2:0]  beat_now;
	logic        ins_reg;
	logic        strip_reg;
	logic [15:0] tpid_reg;
	logic [15:0] tci_reg;
	logic [15:0] out_data_reg;
	logic        out_valid_reg;
	logic        out_sop_reg;
	logic        out_eop_reg;
	logic        can_load;
	logic        emit;
	logic [15:0] emit_data;
	logic        emit_eop;
	logic        is_tag;
	logic        sop_take;

	assign can_load = !out_valid_reg || out_ready;
	assign beat_now = in_sop ? 3'h0 : beat_reg;
	assign is_tag = (in_data == flow_tag_pkg::service_tpid) ||
		(in_data == flow_tag_pkg::customer_tpid);
	assign sop_take = (state_reg == s_addr) && in_valid && in_ready && in_sop;

	always_comb begin
		state_next = state_reg;
		in_ready = 1'b0;
		emit = 1'b0;
		emit_data = in_data;
		emit_eop = in_eop;
		case (state_reg)
		s_addr: begin
			if (in_sop && hdr_drop) begin
				in_ready = 1'b1;
				if (in_valid)
					state_next = in_eop ? s_addr : s_drop;
			end else begin
				in_ready = can_load;
				emit = in_valid && can_load;
				if (emit && !in_eop &&
					beat_now == flow_tag_pkg::header_beats - 3'h1)
					state_next = s_type;
			end
		end
		s_type: begin
			if (in_valid) begin
				if (strip_reg && is_tag) begin
					in_ready = 1'b1;
					state_next = in_eop ? s_addr : s_strip;
				end else if (ins_reg) begin
					// Tag goes right after the source address: outermost
					state_next = s_tpid;
				end else begin
					in_ready = can_load;
					emit = can_load;
					if (emit)
						state_next = in_eop ? s_addr : s_body;
				end
			end
		end
		s_strip: begin
			in_ready = 1'b1;
			if (in_valid)
				state_next = in_eop ? s_addr : s_type;
		end
		s_tpid: begin
			emit = can_load;
			emit_data = tpid_reg;
			emit_eop = 1'b0;
			if (can_load)
				state_next = s_tci;
		end
		s_tci: begin
			emit = can_load;
			emit_data = tci_reg;
			emit_eop = 1'b0;
			if (can_load)
				state_next = s_type;
		end
		s_body: begin
			in_ready = can_load;
			emit = in_valid && can_load;
			if (emit && in_eop)
				state_next = s_addr;
		end
		s_drop: begin
			in_ready = 1'b1;
			if (in_valid && in_eop)
				state_next = s_addr;
		end
		default: state_next = s_addr;
		endcase
		in_ready &= can_load;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			state_reg <= s_addr;
		else if (can_load)
			state_reg <= state_next;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			beat_reg <= 3'h0;
		else if (state_reg == s_addr && in_valid && in_ready)
			beat_reg <= beat_now + 3'h1;
	end

	// Header decision is taken once per packet, with its first beat
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ins_reg <= 1'b0;
			strip_reg <= 1'b0;
			tpid_reg <= 16'h0000;
			tci_reg <= 16'h0000;
		end else if (sop_take) begin
			ins_reg <= hdr_insert;
			strip_reg <= hdr_strip;
			tpid_reg <= hdr_tpid;
			tci_reg <= hdr_tci;
		end else if (state_reg == s_tci && can_load) begin
			ins_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= 16'h0000;
			out_sop_reg <= 1'b0;
			out_eop_reg <= 1'b0;
		end else if (emit) begin
			out_valid_reg <= 1'b1;
			out_data_reg <= emit_data;
			out_sop_reg <= (state_reg == s_addr) && in_sop;
			out_eop_reg <= emit_eop;
		end else if (out_ready) begin
			out_valid_reg <= 1'b0;
		end
	end

	assign out_data = out_data_reg;
	assign out_valid = out_valid_reg;
	assign out_sop = out_sop_reg;
	assign out_eop = out_eop_reg;
endmodule // tag_inserter
`default_nettype wire

// *** service_flow_vlan_tagger.sv ***
// Functional notes
// - Downstream unicast packets get a service_flow_tag naming their flow.
// - Downstream service_flow_tag sits outermost, before other VLAN tags.
// - Upstream packets from a cable_modem get a service_flow_tag.
// - Upstream service_flow_tag sits outermost, ahead of other VLAN tags.
// - Service_flow_tag protocol identifier is always 0x88a8.
// - PCP is only a flow identifier; it never changes QoS handling.
// - CFI bit of the service_flow_tag is always zero.
// - Assigned VIDs lie within 0x801 to 0x9d0 inclusive.
// - Low nine VID bits are the modem_index, same for one cable_modem.
// - One VID and PCP pair maps to one flow per direction.
// - Downstream packets of one VID and PCP pair share a queue, in order.
// - Queue scheduling uses flow QoS parameters only, never PCP.
// - Upstream allocation and handling do not depend on PCP.
// - Flows of one modem and direction get distinct PCP values.
// - PCP may reflect relative priority, zero lowest, seven highest.
// - Associations are set on admit or activate; a release frees one.
// - Deleting a flow frees its VID and PCP pair automatically.
// - Upstream flows map to VLAN IDs by a global table keyed by class.
// - Upstream traffic priority is used directly as the 802.1Q priority.
// - Dynamic flows use one common VLAN and priority, or the class table.
// - Downstream network tags are removed before flow classification.
// - Without routing, flows are mapped to VLANs on the network side.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module service_flow_vlan_tagger #(
	parameter int IDX_W   = 4,
	parameter int CLASS_W = 4
) (
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire logic [7:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic [31:0]             rdata,
	input  wire logic [15:0]        ds_in_data,
	input  wire logic               ds_in_valid,
	input  wire logic               ds_in_sop,
	input  wire logic               ds_in_eop,
	input  wire logic               ds_in_unicast,
	input  wire logic [IDX_W-1:0]   ds_in_flow,
	output logic                    ds_in_ready,
	output logic [15:0]             ds_out_data,
	output logic                    ds_out_valid,
	output logic                    ds_out_sop,
	output logic                    ds_out_eop,
	output logic [IDX_W-1:0]        ds_out_queue,
	output logic [8:0]              ds_out_modem_index,
	input  wire logic               ds_out_ready,
	input  wire logic [15:0]        us_in_data,
	input  wire logic               us_in_valid,
	input  wire logic               us_in_sop,
	input  wire logic               us_in_eop,
	input  wire logic [IDX_W-1:0]   us_in_flow,
	input  wire logic [CLASS_W-1:0] us_in_class,
	input  wire logic [2:0]         us_in_priority,
	input  wire logic               us_in_dynamic,
	output logic                    us_in_ready,
	output logic [15:0]             us_out_data,
	output logic                    us_out_valid,
	output logic                    us_out_sop,
	output logic                    us_out_eop,
	input  wire logic               us_out_ready
);
	localparam int FLOWS   = 1 << IDX_W;
	localparam int CLASSES = 1 << CLASS_W;

	function automatic logic vid_in_range(input logic [11:0] vid);
		vid_in_range = (vid >= flow_tag_pkg::vid_min) &&
			(vid <= flow_tag_pkg::vid_max);
	endfunction

	function automatic logic [15:0] make_tci(input logic [2:0] pcp,
		input logic [11:0] vid);
		make_tci = {pcp, 1'b0, vid};
	endfunction

	logic [3:0]          ctrl_reg;
	logic [FLOWS-1:0]    flow_valid_reg;
	logic [FLOWS-1:0]    flow_dir_reg;
	logic [11:0]         flow_vid_reg [FLOWS];
	logic [2:0]          flow_pcp_reg [FLOWS];
	logic [11:0]         class_vid_reg [CLASSES];
	logic [14:0]         common_reg;
	logic [1:0]          status_reg;
	logic [IDX_W-1:0]    sel_reg;
	logic [15:0]         ds_drop_reg;
	logic [15:0]         us_drop_reg;
	logic [31:0]         rdata_reg;
	logic [IDX_W-1:0]    ds_queue_reg;
	logic [8:0]          ds_modem_reg;

	logic                assoc_write;
	logic [IDX_W-1:0]    cmd_idx;
	logic [11:0]         cmd_vid;
	logic [2:0]          cmd_pcp;
	logic                cmd_dir;
	logic [1:0]          cmd_op;
	logic                cmd_range_bad;
	logic                cmd_dup;
	logic                cmd_accept;

	assign assoc_write = wr && addr == flow_tag_pkg::assoc_offset;
	assign cmd_idx = wdata[flow_tag_pkg::idx_lsb +: IDX_W];
	assign cmd_vid = wdata[flow_tag_pkg::vid_lsb +: 12];
	assign cmd_pcp = wdata[flow_tag_pkg::pcp_lsb +: 3];
	assign cmd_dir = wdata[flow_tag_pkg::dir_bit];
	assign cmd_op = wdata[flow_tag_pkg::op_lsb +: 2];
	assign cmd_range_bad = !vid_in_range(cmd_vid);

	// Any other live entry already owning this pair in this direction
	always_comb begin
		cmd_dup = 1'b0;
		for (int i = 0; i < FLOWS; i++) begin
			if (flow_valid_reg[i] && IDX_W'(i) != cmd_idx &&
				flow_dir_reg[i] == cmd_dir &&
				flow_vid_reg[i] == cmd_vid &&
				flow_pcp_reg[i] == cmd_pcp)
				cmd_dup = 1'b1;
		end
	end

	assign cmd_accept = assoc_write && cmd_op == flow_tag_pkg::op_add &&
		!cmd_range_bad && !cmd_dup;

	always_ff @(posedge sys_clk) begin
		if (reset)
			ctrl_reg <= flow_tag_pkg::ctrl_reset;
		else if (wr && addr == flow_tag_pkg::ctrl_offset)
			ctrl_reg <= wdata[flow_tag_pkg::ctrl_width-1:0];
	end

	// Association table, written when a flow is admitted or activated
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flow_valid_reg <= '0;
		end else if (cmd_accept) begin
			flow_valid_reg[cmd_idx] <= 1'b1;
		end else if (assoc_write && (cmd_op == flow_tag_pkg::op_release ||
			cmd_op == flow_tag_pkg::op_flow_delete)) begin
			flow_valid_reg[cmd_idx] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (cmd_accept) begin
			flow_vid_reg[cmd_idx] <= cmd_vid;
			flow_pcp_reg[cmd_idx] <= cmd_pcp;
			flow_dir_reg[cmd_idx] <= cmd_dir;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status_reg <= 2'h0;
			sel_reg <= '0;
		end else if (assoc_write) begin
			sel_reg <= cmd_idx;
			if (cmd_op == flow_tag_pkg::op_add) begin
				status_reg[flow_tag_pkg::status_range_bit] <= cmd_range_bad;
				status_reg[flow_tag_pkg::status_dup_bit] <= cmd_dup;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			common_reg <= flow_tag_pkg::common_reset;
		else if (wr && addr == flow_tag_pkg::common_offset)
			common_reg <= wdata[14:0];
	end

	always_ff @(posedge sys_clk) begin
		if (wr && addr == flow_tag_pkg::class_offset)
			class_vid_reg[wdata[CLASS_W-1:0]] <=
				wdata[flow_tag_pkg::class_vid_lsb +: 12];
	end

	// Downstream header decision
	logic        ds_entry_ok;
	logic        ds_insert;
	logic        ds_drop;
	logic [15:0] ds_tci;
	logic        ds_take;

	assign ds_entry_ok = flow_valid_reg[ds_in_flow] &&
		flow_dir_reg[ds_in_flow] == flow_tag_pkg::dir_down;
	assign ds_insert = ds_in_unicast && ds_entry_ok;
	assign ds_drop = ds_in_unicast && !ds_entry_ok;
	assign ds_tci = make_tci(flow_pcp_reg[ds_in_flow],
		flow_vid_reg[ds_in_flow]);
	assign ds_take = ds_in_valid && ds_in_ready && ds_in_sop;

	// Queue follows the flow entry, which is one VID and PCP pair; the PCP
	// value itself never selects a queue or a priority.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ds_queue_reg <= '0;
			ds_modem_reg <= 9'h000;
		end else if (ds_take && ds_insert) begin
			ds_queue_reg <= ds_in_flow;
			ds_modem_reg <= flow_vid_reg[ds_in_flow]
				[flow_tag_pkg::modem_index_width-1:0];
		end
	end

	tag_inserter ds_path (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.in_data    (ds_in_data),
		.in_valid   (ds_in_valid),
		.in_sop     (ds_in_sop),
		.in_eop     (ds_in_eop),
		.in_ready   (ds_in_ready),
		.hdr_insert (ds_insert),
		.hdr_drop   (ds_drop),
		.hdr_strip  (ctrl_reg[flow_tag_pkg::ctrl_strip_bit]),
		.hdr_tpid   (flow_tag_pkg::service_tpid),
		.hdr_tci    (ds_tci),
		.out_data   (ds_out_data),
		.out_valid  (ds_out_valid),
		.out_sop    (ds_out_sop),
		.out_eop    (ds_out_eop),
		.out_ready  (ds_out_ready)
	);

	// Upstream header decision: service tag toward the forwarding side, or
	// the network VLAN mapping when this end faces the network.
	logic        us_net;
	logic        us_use_common;
	logic        us_entry_ok;
	logic        us_insert;
	logic        us_drop;
	logic [15:0] us_tpid;
	logic [15:0] us_tci;
	logic [11:0] us_map_vid;
	logic [2:0]  us_map_pcp;
	logic        us_take;

	assign us_net = ctrl_reg[flow_tag_pkg::ctrl_net_bit];
	assign us_use_common = us_in_dynamic &&
		ctrl_reg[flow_tag_pkg::ctrl_common_bit];
	assign us_entry_ok = flow_valid_reg[us_in_flow] &&
		flow_dir_reg[us_in_flow] == flow_tag_pkg::dir_up;
	assign us_map_vid = us_use_common ? common_reg[11:0] :
		class_vid_reg[us_in_class];
	assign us_map_pcp = us_use_common ?
		common_reg[flow_tag_pkg::common_pcp_lsb +: 3] :
		us_in_priority;

	always_comb begin
		if (us_net) begin
			// Routing ends skip the mapping; bridging ends must apply it
			us_insert = !ctrl_reg[flow_tag_pkg::ctrl_route_bit];
			us_drop = 1'b0;
			us_tpid = flow_tag_pkg::customer_tpid;
			us_tci = make_tci(us_map_pcp, us_map_vid);
		end else begin
			// PCP only rides along in the tag, it steers nothing here
			us_insert = us_entry_ok;
			us_drop = !us_entry_ok;
			us_tpid = flow_tag_pkg::service_tpid;
			us_tci = make_tci(flow_pcp_reg[us_in_flow],
				flow_vid_reg[us_in_flow]);
		end
	end

	assign us_take = us_in_valid && us_in_ready && us_in_sop;

	tag_inserter us_path (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.in_data    (us_in_data),
		.in_valid   (us_in_valid),
		.in_sop     (us_in_sop),
		.in_eop     (us_in_eop),
		.in_ready   (us_in_ready),
		.hdr_insert (us_insert),
		.hdr_drop   (us_drop),
		.hdr_strip  (1'b0),
		.hdr_tpid   (us_tpid),
		.hdr_tci    (us_tci),
		.out_data   (us_out_data),
		.out_valid  (us_out_valid),
		.out_sop    (us_out_sop),
		.out_eop    (us_out_eop),
		.out_ready  (us_out_ready)
	);

	// Drop counters saturate; a drop in the clearing cycle still counts
	logic drop_clear;
	assign drop_clear = wr && addr == flow_tag_pkg::drop_offset;

	always_ff @(posedge sys_clk) begin
		if (reset)
			ds_drop_reg <= 16'h0000;
		else if (ds_take && ds_drop)
			ds_drop_reg <= drop_clear ? 16'h0001 :
				(&ds_drop_reg ? ds_drop_reg : ds_drop_reg + 16'h0001);
		else if (drop_clear)
			ds_drop_reg <= 16'h0000;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			us_drop_reg <= 16'h0000;
		else if (us_take && us_drop)
			us_drop_reg <= drop_clear ? 16'h0001 :
				(&us_drop_reg ? us_drop_reg : us_drop_reg + 16'h0001);
		else if (drop_clear)
			us_drop_reg <= 16'h0000;
	end

	always_ff @(posedge sys_clk) begin
		if (reset || !rd) begin
			rdata_reg <= 32'h00000000;
		end else begin
			case (addr)
			flow_tag_pkg::ctrl_offset:
				rdata_reg <= {28'h0000000, ctrl_reg};
			flow_tag_pkg::assoc_offset: begin
				rdata_reg <= 32'h00000000;
				rdata_reg[flow_tag_pkg::valid_bit] <= flow_valid_reg[sel_reg];
				rdata_reg[flow_tag_pkg::dir_bit] <= flow_dir_reg[sel_reg];
				rdata_reg[flow_tag_pkg::pcp_lsb +: 3] <= flow_pcp_reg[sel_reg];
				rdata_reg[flow_tag_pkg::vid_lsb +: 12] <= flow_vid_reg[sel_reg];
				rdata_reg[flow_tag_pkg::idx_lsb +: IDX_W] <= sel_reg;
			end
			flow_tag_pkg::status_offset:
				rdata_reg <= {30'h00000000, status_reg};
			flow_tag_pkg::drop_offset:
				rdata_reg <= {us_drop_reg, ds_drop_reg};
			flow_tag_pkg::common_offset:
				rdata_reg <= {17'h00000, common_reg};
			default:
				rdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign rdata = rdata_reg;
	assign ds_out_queue = ds_queue_reg;
	assign ds_out_modem_index = ds_modem_reg;
endmodule // service_flow_vlan_tagger
`default_nettype wire

// *** stream_sink.sv ***
`timescale 1ns/10ps
`default_nettype none
module stream_sink (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic slow,
	output logic      ready
);
	logic [1:0] tick_reg;

	always_ff @(posedge sys_clk) begin
		if (reset)
			tick_reg <= 2'h0;
		else
			tick_reg <= tick_reg + 2'h1;
	end

	// Stalls follow a fixed pattern and never look at the tag's priority bits
	assign ready = !slow || tick_reg == 2'h0;
endmodule // stream_sink
`default_nettype wire

// *** flow_tag_checker_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module flow_tag_checker (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        ds_in_ready,
	input wire logic [15:0] ds_out_data,
	input wire logic        ds_out_valid,
	input wire logic        ds_out_sop,
	input wire logic        ds_out_eop,
	input wire logic        ds_out_ready,
	input wire logic [8:0]  ds_out_modem_index,
	input wire logic [15:0] us_out_data,
	input wire logic        us_out_valid,
	input wire logic        us_out_sop,
	input wire logic        us_out_eop,
	input wire logic        us_out_ready
);
	logic [3:0] ds_beat_reg;
	logic [3:0] us_beat_reg;
	logic       ds_stag_reg;
	logic       us_stag_reg;

	// Beat position in the outgoing packet; saturates on long packets
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ds_beat_reg <= 4'h0;
			ds_stag_reg <= 1'b0;
		end else if (ds_out_valid && ds_out_ready) begin
			ds_beat_reg <= ds_out_eop ? 4'h0
				: ds_beat_reg + {3'h0, ds_beat_reg != 4'hf};
			if (ds_beat_reg == 4'h6)
				ds_stag_reg <= ds_out_data == flow_tag_pkg::service_tpid;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			us_beat_reg <= 4'h0;
			us_stag_reg <= 1'b0;
		end else if (us_out_valid && us_out_ready) begin
			us_beat_reg <= us_out_eop ? 4'h0
				: us_beat_reg + {3'h0, us_beat_reg != 4'hf};
			if (us_beat_reg == 4'h6)
				us_stag_reg <= us_out_data == flow_tag_pkg::service_tpid;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read reply");
	a_ds_hold: assert property (ds_out_valid && !ds_out_ready |=>
		ds_out_valid && $stable({ds_out_data, ds_out_sop, ds_out_eop}))
		else $error("downstream beat changed while stalled");
	a_us_hold: assert property (us_out_valid && !us_out_ready |=>
		us_out_valid && $stable({us_out_data, us_out_sop, us_out_eop}))
		else $error("upstream beat changed while stalled");
	a_ds_backpressure: assert property (
		ds_out_valid && !ds_out_ready |-> !ds_in_ready)
		else $error("downstream input ready while output stalled");
	a_ds_sop_first: assert property (
		ds_out_valid && ds_beat_reg == 4'h0 |-> ds_out_sop)
		else $error("downstream packet lacks start mark");
	a_us_sop_first: assert property (
		us_out_valid && us_beat_reg == 4'h0 |-> us_out_sop)
		else $error("upstream packet lacks start mark");
	a_ds_tag_fields: assert property (
		ds_out_valid && ds_beat_reg == 4'h7 && ds_stag_reg |->
		!ds_out_data[12] && ds_out_data[11:0] >= flow_tag_pkg::vid_min
		&& ds_out_data[11:0] <= flow_tag_pkg::vid_max)
		else $error("downstream tag control word malformed");
	a_ds_modem_index: assert property (
		ds_out_valid && ds_beat_reg == 4'h7 && ds_stag_reg |->
		ds_out_data[8:0] == ds_out_modem_index)
		else $error("modem index differs from tag");
	a_us_tag_fields: assert property (
		us_out_valid && us_beat_reg == 4'h7 && us_stag_reg |->
		!us_out_data[12] && us_out_data[11:0] >= flow_tag_pkg::vid_min
		&& us_out_data[11:0] <= flow_tag_pkg::vid_max)
		else $error("upstream tag control word malformed");
endmodule // flow_tag_checker

bind service_flow_vlan_tagger flow_tag_checker chk (.sys_clk, .reset, .rd,
	.rdata, .ds_in_ready, .ds_out_data, .ds_out_valid, .ds_out_sop,
	.ds_out_eop, .ds_out_ready, .ds_out_modem_index, .us_out_data,
	.us_out_valid, .us_out_sop, .us_out_eop, .us_out_ready);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top;
	localparam logic [1:0] add_op = flow_tag_pkg::op_add;
	localparam logic [7:0] drops  = flow_tag_pkg::drop_offset;
	localparam logic [7:0] ctrl   = flow_tag_pkg::ctrl_offset;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        bv = 1'b0;
	logic        bup = 1'b0;
	logic [15:0] bd = 16'h0;
	logic        bsop = 1'b0;
	logic        beop = 1'b0;
	logic [15:0] ds_in_data, us_in_data, ds_out_data, us_out_data;
	logic        ds_in_valid, ds_in_sop, ds_in_eop, ds_in_ready;
	logic        us_in_valid, us_in_sop, us_in_eop, us_in_ready;
	logic        ds_in_unicast = 1'b0;
	logic [3:0]  ds_in_flow = 4'h0;
	logic        ds_out_valid, ds_out_sop, ds_out_eop, ds_out_ready;
	logic [3:0]  ds_out_queue;
	logic [8:0]  ds_out_modem_index;
	logic [3:0]  us_in_flow = 4'h0;
	logic [3:0]  us_in_class = 4'h0;
	logic [2:0]  us_in_priority = 3'h0;
	logic        us_in_dynamic = 1'b0;
	logic        us_out_valid, us_out_sop, us_out_eop, us_out_ready;
	logic        slow = 1'b0;
	logic        rd_seen = 1'b0;
	int          num_errors = 0;
	int          n_checks = 0;
	logic [15:0] b[16];
	logic [16:0] e;
	logic [31:0] er;
	logic [16:0] dq[$];
	logic [16:0] uq[$];
	logic [31:0] rq[$];

	assign ds_in_data = bd;
	assign us_in_data = bd;
	assign ds_in_sop = bsop;
	assign us_in_sop = bsop;
	assign ds_in_eop = beop;
	assign us_in_eop = beop;
	assign ds_in_valid = bv && !bup;
	assign us_in_valid = bv && bup;

	service_flow_vlan_tagger DUT (.*);
	stream_sink ds_sink (.sys_clk, .reset, .slow, .ready(ds_out_ready));
	stream_sink us_sink (.sys_clk, .reset, .slow, .ready(us_out_ready));

	initial forever #12.5 sys_clk = ~sys_clk;

	// Sampling mid-cycle keeps the result free of edge ordering races
	always @(negedge sys_clk) begin
		if (rd_seen) begin
			er = rq.pop_front();
			`CHK(rdata, er)
		end
		rd_seen = rd;
		if (ds_out_valid && ds_out_ready) begin
			e = dq.size() != 0 ? dq.pop_front() : ~{ds_out_eop, ds_out_data};
			`CHK({ds_out_eop, ds_out_data}, e)
		end
		if (us_out_valid && us_out_ready) begin
			e = uq.size() != 0 ? uq.pop_front() : ~{us_out_eop, us_out_data};
			`CHK({us_out_eop, us_out_data}, e)
		end
	end

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] x);
		addr <= a;
		rd <= 1'b1;
		rq.push_back(x);
		@(posedge sys_clk);
		rd <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic assoc(input logic [1:0] op, input logic dir,
		input logic [2:0] pcp, input logic [11:0] vid, input logic [3:0] idx,
		input logic [1:0] st);
		reg_wr(flow_tag_pkg::assoc_offset, {10'h0, op, dir, pcp, vid, idx});
		if (op == add_op)
			reg_rd(flow_tag_pkg::status_offset, {30'h0, st});
	endtask

	task automatic pq(input bit up, input logic [16:0] v);
		if (up)
			uq.push_back(v);
		else
			dq.push_back(v);
	endtask

	// m: 0 dropped, 1 passed unchanged, 2 tagged with tp and tci
	task automatic tx(input bit up, input int n, input int m,
		input logic [15:0] tp, input logic [15:0] tci, input bit strip);
		logic r;
		for (int i = 0; i < n; i++)
			b[i] = 16'($urandom);
		if (strip) begin
			b[6] = 16'h8100;
			b[8] = b[8] & 16'h7fff;
		end
		for (int i = 0; i < n && m != 0; i++) begin
			if (i == 6 && m == 2) begin
				pq(up, {1'b0, tp});
				pq(up, {1'b0, tci});
			end
			if (!strip || (i != 6 && i != 7))
				pq(up, {i == n - 1, b[i]});
		end
		bup <= up;
		for (int i = 0; i < n; i++) begin
			bv <= 1'b1;
			bd <= b[i];
			bsop <= i == 0;
			beop <= i == n - 1;
			do begin
				@(negedge sys_clk);
				r = up ? us_in_ready : ds_in_ready;
				@(posedge sys_clk);
			end while (!r);
		end
		bv <= 1'b0;
		@(posedge sys_clk);
		for (int k = 0; k < 300 && dq.size() + uq.size() != 0; k++)
			@(posedge sys_clk);
		`CHK(dq.size() + uq.size(), 0)
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		$display("[ERR] %0t run hung", $time);
		end_sim;
	end

	initial begin
		void'($urandom(32'h03657d41));
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		reg_rd(ctrl, 32'h0);
		reg_rd(8'h20, 32'h0);
		assoc(add_op, 1'b0, 3'h5, 12'h801, 4'h1, 2'h0);
		assoc(add_op, 1'b0, 3'h1, 12'h800, 4'h2, 2'h1);
		assoc(add_op, 1'b0, 3'h1, 12'h9d1, 4'h2, 2'h1);
		assoc(add_op, 1'b0, 3'h5, 12'h801, 4'h3, 2'h2);
		assoc(add_op, 1'b1, 3'h5, 12'h801, 4'h4, 2'h0);
		assoc(add_op, 1'b1, 3'h7, 12'h9d0, 4'h5, 2'h0);
		reg_rd(flow_tag_pkg::assoc_offset, 32'h800f9d05);
		ds_in_unicast <= 1'b1;
		ds_in_flow <= 4'h1;
		tx(1'b0, 8, 2, 16'h88a8, 16'ha801, 1'b0);
		`CHK(ds_out_queue, 4'h1)
		`CHK(ds_out_modem_index, 9'h001)
		slow <= 1'b1;
		ds_in_unicast <= 1'b0;
		tx(1'b0, 7, 1, 16'h0, 16'h0, 1'b0);
		ds_in_unicast <= 1'b1;
		ds_in_flow <= 4'h2;
		tx(1'b0, 8, 0, 16'h0, 16'h0, 1'b0);
		ds_in_flow <= 4'h4;
		tx(1'b0, 8, 0, 16'h0, 16'h0, 1'b0);
		reg_rd(drops, 32'h2);
		assoc(2'h2, 1'b0, 3'h5, 12'h801, 4'h1, 2'h0);
		ds_in_flow <= 4'h1;
		tx(1'b0, 8, 0, 16'h0, 16'h0, 1'b0);
		assoc(add_op, 1'b0, 3'h5, 12'h801, 4'h1, 2'h0);
		assoc(2'h3, 1'b0, 3'h5, 12'h801, 4'h1, 2'h0);
		tx(1'b0, 8, 0, 16'h0, 16'h0, 1'b0);
		assoc(add_op, 1'b0, 3'h5, 12'h801, 4'h3, 2'h0);
		reg_rd(drops, 32'h4);
		reg_wr(drops, 32'h0);
		reg_rd(drops, 32'h0);
		us_in_flow <= 4'h5;
		tx(1'b1, 8, 2, 16'h88a8, 16'he9d0, 1'b0);
		us_in_flow <= 4'h2;
		tx(1'b1, 8, 0, 16'h0, 16'h0, 1'b0);
		reg_rd(drops, 32'h00010000);
		reg_wr(ctrl, 32'h2);
		reg_wr(flow_tag_pkg::class_offset, 32'h1233);
		reg_rd(flow_tag_pkg::class_offset, 32'h0);
		us_in_class <= 4'h3;
		us_in_priority <= 3'h6;
		for (int f = 5; f < 7; f++) begin
			us_in_flow <= 4'(f);
			tx(1'b1, 8, 2, 16'h8100, 16'hc123, 1'b0);
		end
		reg_wr(ctrl, 32'ha);
		reg_wr(flow_tag_pkg::common_offset, 32'h20aa);
		reg_rd(flow_tag_pkg::common_offset, 32'h20aa);
		us_in_dynamic <= 1'b1;
		tx(1'b1, 8, 2, 16'h8100, 16'h40aa, 1'b0);
		reg_wr(ctrl, 32'h6);
		us_in_dynamic <= 1'b0;
		tx(1'b1, 8, 1, 16'h0, 16'h0, 1'b0);
		reg_wr(ctrl, 32'h1);
		ds_in_flow <= 4'h3;
		tx(1'b0, 10, 2, 16'h88a8, 16'ha801, 1'b1);
		end_sim;
	end
endmodule // tb_top
`default_nettype wire
